// [verilog/pie_irq_mask.sv]
// peripheral interrupt enable mask register and request gating
// Behaviour
// - bit 6 set passes comparator-2 flag requests, clear blocks them.
// - bit 5 set passes comparator-1 flag requests, clear blocks them.
// - bit 3 set passes all counter-array requests, clear masks them.
// - bit 2 clear masks converter-0 window-compare requests, set passes them.
// - bit 1 set passes management-bus serial flag requests, clear blocks them.
`timescale 1ns/1ps
module pie_irq_mask
   import pie_pkg::*;
(
   // clock, reset, enable
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // register access
   input  wire pie_sfr_req_t sfr_req,
   output logic [7:0]        sfr_rdata,
   output logic              sfr_hit,
   // peripheral requests, same bit order as the mask
   input  wire logic [7:0]   periph_req,
   // to core interrupt logic
   output logic [7:0]        core_req,
   output pie_mask_t         mask_out
);

   // stored enable bits, one flop per source
   logic       conv0_done_irq_en;
   logic       cmp2_irq_en;
   logic       cmp1_irq_en;
   logic       cmp0_irq_en;
   logic       counter_array_irq_en;
   logic       conv0_window_irq_en;
   logic       mgmt_bus_irq_en;
   logic       serial_periph_irq_en;
   // packed views of the enable bits and of the gated requests
   pie_mask_t  mask;
   pie_mask_t  next_mask;
   logic [7:0] mask_bits;
   logic [7:0] gated;

   // mask register decodes on every page
   function automatic logic addr_hit(input logic [7:0] addr);
      return addr == PIE_MASK_ADDR;
   endfunction : addr_hit

   // one enable bit after a possible write
   function automatic logic bit_next(
      input logic       cur,
      input logic       take,
      input logic [7:0] wdata,
      input int         pos
   );
      return take ? wdata[pos] : cur;
   endfunction : bit_next

   // access decode; writes only taken while enabled
   wire        sel    = addr_hit(sfr_req.addr);
   wire        wr_en  = ce && sfr_req.wr && sel;
   wire        rd_en  = sfr_req.rd && sel;
   wire        acc_en = (sfr_req.rd || sfr_req.wr) && sel;

   // next value of each enable bit
   wire        next_conv0_done_irq_en =
      bit_next(conv0_done_irq_en, wr_en, sfr_req.wdata, PIE_BIT_CONV0_DONE);
   wire        next_cmp2_irq_en =
      bit_next(cmp2_irq_en, wr_en, sfr_req.wdata, PIE_BIT_CMP2);
   wire        next_cmp1_irq_en =
      bit_next(cmp1_irq_en, wr_en, sfr_req.wdata, PIE_BIT_CMP1);
   wire        next_cmp0_irq_en =
      bit_next(cmp0_irq_en, wr_en, sfr_req.wdata, PIE_BIT_CMP0);
   wire        next_counter_array_irq_en =
      bit_next(counter_array_irq_en, wr_en, sfr_req.wdata, PIE_BIT_COUNTER_ARR);
   wire        next_conv0_window_irq_en =
      bit_next(conv0_window_irq_en, wr_en, sfr_req.wdata, PIE_BIT_CONV0_WINDOW);
   wire        next_mgmt_bus_irq_en =
      bit_next(mgmt_bus_irq_en, wr_en, sfr_req.wdata, PIE_BIT_MGMT_BUS);
   wire        next_serial_periph_irq_en =
      bit_next(serial_periph_irq_en, wr_en, sfr_req.wdata, PIE_BIT_SERIAL_PERIPH);

   // converter 0 end of conversion enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv0_done_irq_en <= PIE_MASK_RESET[PIE_BIT_CONV0_DONE];
      end else if (ce) begin
         conv0_done_irq_en <= next_conv0_done_irq_en;
      end
   end

   // comparator 2 enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp2_irq_en <= PIE_MASK_RESET[PIE_BIT_CMP2];
      end else if (ce) begin
         cmp2_irq_en <= next_cmp2_irq_en;
      end
   end

   // comparator 1 enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp1_irq_en <= PIE_MASK_RESET[PIE_BIT_CMP1];
      end else if (ce) begin
         cmp1_irq_en <= next_cmp1_irq_en;
      end
   end

   // comparator 0 enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp0_irq_en <= PIE_MASK_RESET[PIE_BIT_CMP0];
      end else if (ce) begin
         cmp0_irq_en <= next_cmp0_irq_en;
      end
   end

   // counter array enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         counter_array_irq_en <= PIE_MASK_RESET[PIE_BIT_COUNTER_ARR];
      end else if (ce) begin
         counter_array_irq_en <= next_counter_array_irq_en;
      end
   end

   // converter 0 window compare enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conv0_window_irq_en <= PIE_MASK_RESET[PIE_BIT_CONV0_WINDOW];
      end else if (ce) begin
         conv0_window_irq_en <= next_conv0_window_irq_en;
      end
   end

   // management bus enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_bus_irq_en <= PIE_MASK_RESET[PIE_BIT_MGMT_BUS];
      end else if (ce) begin
         mgmt_bus_irq_en <= next_mgmt_bus_irq_en;
      end
   end

   // serial peripheral enable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serial_periph_irq_en <= PIE_MASK_RESET[PIE_BIT_SERIAL_PERIPH];
      end else if (ce) begin
         serial_periph_irq_en <= next_serial_periph_irq_en;
      end
   end

   // present and next mask, msb first as in the struct
   assign mask = pie_mask_t'({
      conv0_done_irq_en,
      cmp2_irq_en,
      cmp1_irq_en,
      cmp0_irq_en,
      counter_array_irq_en,
      conv0_window_irq_en,
      mgmt_bus_irq_en,
      serial_periph_irq_en
   });
   assign next_mask = pie_mask_t'({
      next_conv0_done_irq_en,
      next_cmp2_irq_en,
      next_cmp1_irq_en,
      next_cmp0_irq_en,
      next_counter_array_irq_en,
      next_conv0_window_irq_en,
      next_mgmt_bus_irq_en,
      next_serial_periph_irq_en
   });
   assign mask_bits = mask;

   // one enables, zero masks, per bit
   pie_gate #(
      .N (8)
   ) u_gate (
      .mask  (mask_bits),
      .req   (periph_req),
      .gated (gated)
   );

   // read data shows the mask only for a read of this register
   wire [7:0]  next_sfr_rdata = rd_en ? mask_bits : 8'h00;

   // gated requests, one cycle behind
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_req <= 8'h00;
      end else if (ce) begin
         core_req <= gated;
      end
   end

   // copy of the mask, new value the edge of the write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_out <= pie_mask_t'(PIE_MASK_RESET);
      end else if (ce) begin
         mask_out <= next_mask;
      end
   end

   // registered read data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (ce) begin
         sfr_rdata <= next_sfr_rdata;
      end
   end

   // registered access hit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_hit <= 1'b0;
      end else if (ce) begin
         sfr_hit <= acc_en;
      end
   end

endmodule : pie_irq_mask

// [verilog/pie_pkg.sv]
// package: peripheral interrupt enable mask constants and types
package pie_pkg;

   localparam logic [7:0] PIE_MASK_ADDR  = 8'he6;
   localparam logic [7:0] PIE_MASK_RESET = 8'h00;

   // bit positions
   localparam int PIE_BIT_CONV0_DONE   = 7;
   localparam int PIE_BIT_CMP2         = 6;
   localparam int PIE_BIT_CMP1         = 5;
   localparam int PIE_BIT_CMP0         = 4;
   localparam int PIE_BIT_COUNTER_ARR  = 3;
   localparam int PIE_BIT_CONV0_WINDOW = 2;
   localparam int PIE_BIT_MGMT_BUS     = 1;
   localparam int PIE_BIT_SERIAL_PERIPH = 0;

   typedef struct packed {
      logic conv0_done_irq_en;
      logic cmp2_irq_en;
      logic cmp1_irq_en;
      logic cmp0_irq_en;
      logic counter_array_irq_en;
      logic conv0_window_irq_en;
      logic mgmt_bus_irq_en;
      logic serial_periph_irq_en;
   } pie_mask_t;

   // special function register access from the core
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pie_sfr_req_t;

endpackage : pie_pkg

// [verilog/pie_gate.sv]
// gating of peripheral requests by the enable mask
`timescale 1ns/1ps
module pie_gate
   import pie_pkg::*;
#(
   parameter int N = 8
) (
   // mask and raw requests
   input  wire logic [N-1:0] mask,
   input  wire logic [N-1:0] req,
   // gated requests
   output logic [N-1:0]      gated
);

   assign gated = req & mask;

endmodule : pie_gate

// [test/pie_periph.sv]
// partner: on-chip peripherals raising request levels in a changing pattern
`timescale 1ns/1ps
module pie_periph (
   // clock
   input  wire logic  clk,
   // request levels, same bit order as the mask
   output logic [7:0] periph_req
);

   // odd step visits every pattern, each bit takes both levels
   initial periph_req = 8'h00;
   always @(negedge clk) periph_req <= periph_req + 8'h35;

endmodule : pie_periph

// [test/pie_sva.sv]
// checker: request gating and mask hold, seen from the top ports
`timescale 1ns/1ps
module pie_sva
   import pie_pkg::*;
(
   // clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // requests and mask
   input  wire logic [7:0] periph_req,
   input  wire logic [7:0] core_req,
   input  wire pie_mask_t  mask_out
);

   wire [7:0] gate = periph_req & mask_out;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   cmp2_gate_a : assert property (ce |=> core_req[6] == $past(gate[6]))
      else $error("comparator 2 gating wrong");
   cmp1_gate_a : assert property (ce |=> core_req[5] == $past(gate[5]))
      else $error("comparator 1 gating wrong");
   counter_gate_a : assert property (ce |=> core_req[3] == $past(gate[3]))
      else $error("counter array gating wrong");
   window_gate_a : assert property (ce |=> core_req[2] == $past(gate[2]))
      else $error("window compare gating wrong");
   bus_gate_a : assert property (ce |=> core_req[1] == $past(gate[1]))
      else $error("management bus gating wrong");
   other_gate_a : assert property (ce |=> (core_req & 8'h91) == $past(gate & 8'h91))
      else $error("remaining sources gating wrong");
   mask_hold_a : assert property (!ce |=> $stable(mask_out))
      else $error("mask changed while disabled");

endmodule : pie_sva

bind pie_irq_mask pie_sva pie_sva_inst (
   .clk        (clk),
   .rst_n      (rst_n),
   .ce         (ce),
   .periph_req (periph_req),
   .core_req   (core_req),
   .mask_out   (mask_out)
);

// [test/pie_irq_mask_bench.sv]
// bench: register accesses, refused address, clock enable and mid-run reset
`timescale 1ns/1ps
module pie_irq_mask_bench import pie_pkg::*;;

   int           mismatches   = 0;
   int           total_checks = 0;
   int           cycles       = 0;
   logic         clk          = 1'b0;
   logic         rst_n        = 1'b0;
   logic         ce           = 1'b1;
   logic         sfr_hit;
   logic [7:0]   periph_req;
   logic [7:0]   sfr_rdata;
   logic [7:0]   core_req;
   pie_sfr_req_t sfr_req      = '0;
   pie_mask_t    mask_out;
   // reference of the mask and of the outputs after each edge
   logic [7:0]   ref_mask     = 8'h00;
   logic [7:0]   ref_core     = 8'h00;
   logic [7:0]   ref_rdata    = 8'h00;
   logic         ref_hit      = 1'b0;
   wire          ref_sel      = sfr_req.addr == PIE_MASK_ADDR;

   pie_periph pie_periph_inst (
      .clk        (clk),
      .periph_req (periph_req)
   );

   pie_irq_mask pie_irq_mask_inst (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .sfr_req    (sfr_req),
      .sfr_rdata  (sfr_rdata),
      .sfr_hit    (sfr_hit),
      .periph_req (periph_req),
      .core_req   (core_req),
      .mask_out   (mask_out)
   );

   initial begin
      forever #5 clk = ~clk;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_mask  <= PIE_MASK_RESET;
         ref_core  <= 8'h00;
         ref_rdata <= 8'h00;
         ref_hit   <= 1'b0;
      end else if (ce) begin
         ref_core  <= periph_req & ref_mask;
         ref_rdata <= (sfr_req.rd && ref_sel) ? ref_mask : 8'h00;
         ref_hit   <= (sfr_req.rd || sfr_req.wr) && ref_sel;
         if (sfr_req.wr && ref_sel) begin
            ref_mask <= sfr_req.wdata;
         end
      end
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : compare

   task automatic check_all();
      compare(sfr_rdata, ref_rdata, "read data");
      compare({7'h00, sfr_hit}, {7'h00, ref_hit}, "hit");
      compare(mask_out, ref_mask, "mask copy");
      compare(core_req, ref_core, "gated");
   endtask : check_all

   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk);
      sfr_req = '{wr: wr, rd: !wr, addr: addr, wdata: data};
      @(negedge clk);
      sfr_req = '0;
      check_all();
   endtask : access

   task automatic idle_checks(input int n);
      repeat (n) begin
         @(negedge clk);
         check_all();
      end
   endtask : idle_checks

   initial begin
      while (cycles < 600) begin
         @(posedge clk);
         cycles++;
      end
      mismatches++;
      $display("MISMATCH %0t timeout", $time);
      finish_test();
   end

   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) begin
         access(1'b1, PIE_MASK_ADDR, 8'h01 << i);
         compare(mask_out, 8'h01 << i, "written mask");
         access(1'b0, PIE_MASK_ADDR, 8'h00);
         compare(sfr_rdata, 8'h01 << i, "read back");
      end
      $display("test walking_one done");
      access(1'b1, 8'he7, 8'ha5);
      compare(mask_out, 8'h80, "refused write");
      compare({7'h00, sfr_hit}, 8'h00, "refused hit");
      $display("test refused_address done");
      access(1'b1, PIE_MASK_ADDR, 8'hff);
      idle_checks(8);
      access(1'b1, PIE_MASK_ADDR, 8'h00);
      idle_checks(8);
      compare(core_req, 8'h00, "all masked");
      $display("test pass_and_mask done");
      access(1'b1, PIE_MASK_ADDR, 8'h6e);
      @(negedge clk);
      ce = 1'b0;
      access(1'b1, PIE_MASK_ADDR, 8'h91);
      compare(mask_out, 8'h6e, "frozen mask");
      idle_checks(3);
      ce = 1'b1;
      idle_checks(2);
      $display("test clock_enable done");
      access(1'b1, PIE_MASK_ADDR, 8'hff);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      compare(mask_out, 8'h00, "mask in reset");
      rst_n = 1'b1;
      access(1'b0, PIE_MASK_ADDR, 8'h00);
      compare(sfr_rdata, 8'h00, "read after reset");
      $display("test mid_reset done");
      finish_test();
   end

endmodule : pie_irq_mask_bench
